/* hdl/svgf_gain_fric.sv */
/*
  Gain set selection with a timed third gain window before stopping,
  and friction compensation added to the torque command.
  Assumes position delta, command speed and torque input are sampled
  once per control tick and are synchronous to clk.
*/
// Notes on behaviour
// [RULE1] Third gain only in position or full-closed mode.
// [RULE2] Third gain is first gain times scale over 100.
// [RULE3] Third gain lasts for the valid time setting.
// [RULE4] Unused feature: valid time 0, scale 100.
// [RULE5] Window swaps only position and speed proportional gains.
// [RULE6] Other first-gain filters stay unscaled in window.
// [RULE7] Second condition during window selects second gain.
// [RULE8] Second to third transition ramps over ramp time.
// [RULE9] Second-to-first return enters the window when third gain is enabled and valid time is nonzero.
// [RULE10] Selector 7 uses position command presence.
// [RULE11] Offset torque added except in torque mode.
// [RULE12] Forward command adds forward friction value.
// [RULE13] Reverse command adds reverse friction value.
// [RULE14] Two-degree mode adds speed times viscous gain.
// [RULE15] Offset plus friction terms form total compensation.
// [RULE16] Torque mode forces offset and dynamic to zero.
// [RULE17] Velocity mode: live offset, dynamic held zero.
// [RULE18] Position mode holds values until first command.
// [RULE19] Position mode dynamic follows command direction.
// [RULE20] Third gain only with servo on, position mode.
// [RULE21] Window opens after command end, closes on expiry.
`timescale 1ns/1ps
`default_nettype none

module svgf_gain_fric (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  input  wire logic        gainSwitchCond,
  input  wire logic [15:0] posCmdDelta,
  input  wire logic [15:0] cmdSpeed,
  input  wire logic [15:0] torqueCmdIn,
  output logic      [15:0] posLoopGain,
  output logic      [15:0] speedPropGain,
  output logic      [15:0] torqueCmdOut,
  output logic      [1:0]  gainSelect,
  output logic             ctrlTick
);

  ////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [7:0]  ctrl_ff;
  logic [15:0] gain1Pos_ff;
  logic [15:0] gain1Spd_ff;
  logic [15:0] gain2Pos_ff;
  logic [15:0] gain2Spd_ff;
  logic [15:0] thirdTime_ff;
  logic [15:0] thirdScale_ff;
  logic [15:0] rampTime_ff;
  logic [15:0] offsetTrq_ff;
  logic [15:0] fwdFric_ff;
  logic [15:0] revFric_ff;
  logic [15:0] viscGain_ff;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_ff       <= 8'h00;
      gain1Pos_ff   <= svgf_pkg::RST_ZERO;
      gain1Spd_ff   <= svgf_pkg::RST_ZERO;
      gain2Pos_ff   <= svgf_pkg::RST_ZERO;
      gain2Spd_ff   <= svgf_pkg::RST_ZERO;
      thirdTime_ff  <= svgf_pkg::RST_ZERO;
      thirdScale_ff <= svgf_pkg::RST_SCALE;
      rampTime_ff   <= svgf_pkg::RST_ZERO;
      offsetTrq_ff  <= svgf_pkg::RST_ZERO;
      fwdFric_ff    <= svgf_pkg::RST_ZERO;
      revFric_ff    <= svgf_pkg::RST_ZERO;
      viscGain_ff   <= svgf_pkg::RST_ZERO;
    end
    else if (regWr)
    begin
      case (regAddr)
        svgf_pkg::OFS_CTRL:        ctrl_ff       <= regWdata[7:0];
        svgf_pkg::OFS_GAIN1_POS:   gain1Pos_ff   <= regWdata[15:0];
        svgf_pkg::OFS_GAIN1_SPD:   gain1Spd_ff   <= regWdata[15:0];
        svgf_pkg::OFS_GAIN2_POS:   gain2Pos_ff   <= regWdata[15:0];
        svgf_pkg::OFS_GAIN2_SPD:   gain2Spd_ff   <= regWdata[15:0];
        svgf_pkg::OFS_THIRD_TIME:  thirdTime_ff  <= regWdata[15:0];
        svgf_pkg::OFS_THIRD_SCALE: thirdScale_ff <= regWdata[15:0];
        svgf_pkg::OFS_RAMP_TIME:   rampTime_ff   <= regWdata[15:0];
        svgf_pkg::OFS_OFFSET_TRQ:  offsetTrq_ff  <= regWdata[15:0];
        svgf_pkg::OFS_FWD_FRIC:    fwdFric_ff    <= regWdata[15:0];
        svgf_pkg::OFS_REV_FRIC:    revFric_ff    <= regWdata[15:0];
        svgf_pkg::OFS_VISC_GAIN:   viscGain_ff   <= regWdata[15:0];
        default:                   ctrl_ff       <= ctrl_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control fields and the control-cycle tick.

  wire logic        servoOn = ctrl_ff[svgf_pkg::CTRL_SERVO_BIT];
  wire svgf_pkg::svgf_mode_t ctrlMode =
    svgf_pkg::svgf_mode_t'(ctrl_ff[svgf_pkg::CTRL_MODE_LSB +: 2]);
  wire logic        twoDof  = ctrl_ff[svgf_pkg::CTRL_TWODOF_BIT];
  wire logic [3:0]  swSel   = ctrl_ff[svgf_pkg::CTRL_SWSEL_LSB +: 4];

  wire logic posMode   = (ctrlMode == svgf_pkg::MODE_POS) ||
                         (ctrlMode == svgf_pkg::MODE_FULLC);
  wire logic cmdPresent = (posCmdDelta != 16'h0000);
  wire logic cmdFwd    = cmdPresent && !posCmdDelta[15];
  wire logic cmdRev    = cmdPresent && posCmdDelta[15];
  // Selector 7 ignores the external condition in favour of the command.
  wire logic secondCond = (swSel == svgf_pkg::SWSEL_POS_CMD) ?
                          cmdPresent : gainSwitchCond; // see [RULE10]
  wire logic thirdEnable = servoOn && posMode; // see [RULE1] see [RULE20]

  logic [7:0] tickCnt_ff;
  logic       tick_ff;
  wire logic  tickWrap = (tickCnt_ff == svgf_pkg::TICK_LAST);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tickCnt_ff <= 8'h00;
      tick_ff    <= 1'b0;
    end
    else
    begin
      tickCnt_ff <= tickWrap ? 8'h00 : tickCnt_ff + 8'h01;
      tick_ff    <= tickWrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gain set state machine.

  svgf_pkg::svgf_gstate_t gState_ff;
  svgf_pkg::svgf_gstate_t nxt_gState;
  logic [15:0] validCnt_ff;
  logic [15:0] rampCnt_ff;
  logic [15:0] startPos_ff;
  logic [15:0] startSpd_ff;

  // The window is skipped when its time is zero, so a disabled feature
  // behaves exactly as plain two-set switching.
  wire logic enterThird = thirdEnable &&
                          (thirdTime_ff != 16'h0000); // see [RULE4]

  always_comb
  begin
    nxt_gState = gState_ff;
    case (gState_ff)
      svgf_pkg::GS_FIRST:
        if (secondCond)
          nxt_gState = svgf_pkg::GS_SECOND;
      svgf_pkg::GS_SECOND:
        if (!secondCond)
          nxt_gState = enterThird ? svgf_pkg::GS_THIRD
                                  : svgf_pkg::GS_FIRST; // see [RULE9] see [RULE21]
      svgf_pkg::GS_THIRD:
        if (secondCond)
          nxt_gState = svgf_pkg::GS_SECOND; // see [RULE7]
        else if (!thirdEnable || validCnt_ff <= 16'h0001)
          nxt_gState = svgf_pkg::GS_FIRST; // see [RULE3] see [RULE21]
      default:
        nxt_gState = svgf_pkg::GS_FIRST;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      gState_ff   <= svgf_pkg::GS_FIRST;
      validCnt_ff <= 16'h0000;
      rampCnt_ff  <= 16'h0000;
      startPos_ff <= 16'h0000;
      startSpd_ff <= 16'h0000;
    end
    else if (tick_ff)
    begin
      gState_ff <= nxt_gState;
      if (gState_ff != svgf_pkg::GS_THIRD)
      begin
        // Ramp inputs track the second set until the window opens, so the
        // registered ramp already starts from it on the entry tick.
        rampCnt_ff  <= rampTime_ff; // see [RULE8]
        startPos_ff <= gain2Pos_ff;
        startSpd_ff <= gain2Spd_ff;
        if (nxt_gState == svgf_pkg::GS_THIRD)
          validCnt_ff <= thirdTime_ff; // see [RULE3]
      end
      else
      begin
        validCnt_ff <= (validCnt_ff == 16'h0000) ? 16'h0000
                                                 : validCnt_ff - 16'h0001;
        rampCnt_ff  <= (rampCnt_ff == 16'h0000) ? 16'h0000
                                                : rampCnt_ff - 16'h0001;
      end
    end
  end

  svgf_gain_if gif ();
  assign gif.firstPos = gain1Pos_ff;
  assign gif.firstSpd = gain1Spd_ff;
  assign gif.scale    = thirdScale_ff;
  assign gif.startPos = startPos_ff;
  assign gif.startSpd = startSpd_ff;
  assign gif.rampCnt  = rampCnt_ff;
  assign gif.rampTime = rampTime_ff;

  svgf_gain_calc u_calc (
    .clk   (clk),
    .reset (reset),
    .gif   (gif)
  );

  // Integration time, detection and torque filters are not handled here;
  // the loop keeps the first set for them in every state.
  wire logic [15:0] selPos =
    (gState_ff == svgf_pkg::GS_SECOND) ? gain2Pos_ff :
    (gState_ff == svgf_pkg::GS_THIRD)  ? gif.rampPos :
                                         gain1Pos_ff; // see [RULE5] see [RULE8]
  wire logic [15:0] selSpd =
    (gState_ff == svgf_pkg::GS_SECOND) ? gain2Spd_ff :
    (gState_ff == svgf_pkg::GS_THIRD)  ? gif.rampSpd :
                                         gain1Spd_ff; // see [RULE5] see [RULE6]

  ////////////////////////////////////////////////////////////////////////
  // Friction compensation.

  logic [15:0] offsetAct_ff;
  logic [15:0] dynAct_ff;
  logic        cmdSeen_ff;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      offsetAct_ff <= 16'h0000;
      dynAct_ff    <= 16'h0000;
      cmdSeen_ff   <= 1'b0;
    end
    else if (tick_ff)
    begin
      if (!servoOn || ctrlMode == svgf_pkg::MODE_TRQ)
      begin
        offsetAct_ff <= 16'h0000; // see [RULE16] see [RULE11]
        dynAct_ff    <= 16'h0000; // see [RULE16]
        cmdSeen_ff   <= 1'b0;
      end
      else if (ctrlMode == svgf_pkg::MODE_VEL)
      begin
        offsetAct_ff <= offsetTrq_ff; // see [RULE17] see [RULE11]
        dynAct_ff    <= 16'h0000; // see [RULE17]
      end
      else if (cmdPresent || cmdSeen_ff)
      begin
        cmdSeen_ff   <= 1'b1;
        offsetAct_ff <= offsetTrq_ff; // see [RULE18] see [RULE11]
        if (cmdFwd)
          dynAct_ff <= fwdFric_ff; // see [RULE12] see [RULE19]
        else if (cmdRev)
          dynAct_ff <= revFric_ff; // see [RULE13] see [RULE19]
      end
    end
  end

  // Viscous term is scaled down so that practical gains stay in range.
  wire logic signed [31:0] viscProd = $signed(cmdSpeed) * $signed(viscGain_ff);
  wire logic signed [31:0] viscShift = viscProd >>> svgf_pkg::VISC_SHIFT;
  wire logic signed [17:0] viscTerm =
    (servoOn && posMode && twoDof) ? 18'(viscShift) : 18'sd0; // see [RULE14]
  wire logic signed [17:0] totalComp = 18'($signed(offsetAct_ff)) +
                                       18'($signed(dynAct_ff)) +
                                       viscTerm; // see [RULE15]
  wire logic signed [18:0] trqSum = 19'($signed(torqueCmdIn)) +
                                    19'(totalComp);
  // Saturation keeps a large compensation from wrapping the command sign.
  wire logic [15:0] trqSat =
    (trqSum > 19'sd32767)  ? 16'h7FFF :
    (trqSum < -19'sd32768) ? 16'h8000 : trqSum[15:0];

  ////////////////////////////////////////////////////////////////////////
  // Outputs and register reads.

  wire logic [31:0] rdMux =
    (regAddr == svgf_pkg::OFS_CTRL)        ? {24'h00_0000, ctrl_ff} :
    (regAddr == svgf_pkg::OFS_GAIN1_POS)   ? {16'h0000, gain1Pos_ff} :
    (regAddr == svgf_pkg::OFS_GAIN1_SPD)   ? {16'h0000, gain1Spd_ff} :
    (regAddr == svgf_pkg::OFS_GAIN2_POS)   ? {16'h0000, gain2Pos_ff} :
    (regAddr == svgf_pkg::OFS_GAIN2_SPD)   ? {16'h0000, gain2Spd_ff} :
    (regAddr == svgf_pkg::OFS_THIRD_TIME)  ? {16'h0000, thirdTime_ff} :
    (regAddr == svgf_pkg::OFS_THIRD_SCALE) ? {16'h0000, thirdScale_ff} :
    (regAddr == svgf_pkg::OFS_RAMP_TIME)   ? {16'h0000, rampTime_ff} :
    (regAddr == svgf_pkg::OFS_OFFSET_TRQ)  ? {16'h0000, offsetTrq_ff} :
    (regAddr == svgf_pkg::OFS_FWD_FRIC)    ? {16'h0000, fwdFric_ff} :
    (regAddr == svgf_pkg::OFS_REV_FRIC)    ? {16'h0000, revFric_ff} :
    (regAddr == svgf_pkg::OFS_VISC_GAIN)   ? {16'h0000, viscGain_ff} :
    (regAddr == svgf_pkg::OFS_STATUS)      ? {validCnt_ff, 13'h0000,
                                              cmdSeen_ff, gState_ff} :
    (regAddr == svgf_pkg::OFS_GAIN_NOW)    ? {speedPropGain, posLoopGain} :
    (regAddr == svgf_pkg::OFS_COMP_NOW)    ? {dynAct_ff, offsetAct_ff} :
                                             32'h0000_0000;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      regRdata      <= 32'h0000_0000;
      posLoopGain   <= 16'h0000;
      speedPropGain <= 16'h0000;
      torqueCmdOut  <= 16'h0000;
      gainSelect    <= 2'b00;
      ctrlTick      <= 1'b0;
    end
    else
    begin
      regRdata      <= regRd ? rdMux : 32'h0000_0000;
      posLoopGain   <= selPos;
      speedPropGain <= selSpd;
      torqueCmdOut  <= trqSat;
      gainSelect    <= gState_ff;
      ctrlTick      <= tick_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_no_third; // see [RULE1]
    tick_ff && !posMode |=> gState_ff != svgf_pkg::GS_THIRD;
  endproperty
  a_no_third: assert property (p_no_third) // see [RULE1]
    else $error("third gain entered outside position modes");

  property p_servo_off; // see [RULE20]
    tick_ff && !servoOn && gState_ff == svgf_pkg::GS_SECOND && !secondCond
      |=> gState_ff == svgf_pkg::GS_FIRST;
  endproperty
  a_servo_off: assert property (p_servo_off) // see [RULE20]
    else $error("third gain window opened with servo off");

  property p_enter; // see [RULE9]
    tick_ff && gState_ff == svgf_pkg::GS_SECOND && !secondCond && enterThird
      |=> gState_ff == svgf_pkg::GS_THIRD && validCnt_ff == $past(thirdTime_ff);
  endproperty
  a_enter: assert property (p_enter) // see [RULE9]
    else $error("return from second gain did not open the window");

  property p_expire; // see [RULE3]
    tick_ff && gState_ff == svgf_pkg::GS_THIRD && validCnt_ff == 16'h0001 &&
    !secondCond |=> gState_ff == svgf_pkg::GS_FIRST;
  endproperty
  a_expire: assert property (p_expire) // see [RULE3]
    else $error("third gain window did not close on expiry");

  property p_second_wins; // see [RULE7]
    tick_ff && gState_ff == svgf_pkg::GS_THIRD && secondCond
      |=> gState_ff == svgf_pkg::GS_SECOND;
  endproperty
  a_second_wins: assert property (p_second_wins) // see [RULE7]
    else $error("second condition did not override third gain");

  property p_sel7; // see [RULE10]
    tick_ff && swSel == svgf_pkg::SWSEL_POS_CMD && cmdPresent &&
    gState_ff == svgf_pkg::GS_FIRST |=> gState_ff == svgf_pkg::GS_SECOND;
  endproperty
  a_sel7: assert property (p_sel7) // see [RULE10]
    else $error("position command did not select second gain");

  property p_first_gain; // see [RULE5]
    gState_ff == svgf_pkg::GS_FIRST ##1 gState_ff == svgf_pkg::GS_FIRST
      |-> posLoopGain == $past(gain1Pos_ff) &&
          speedPropGain == $past(gain1Spd_ff);
  endproperty
  a_first_gain: assert property (p_first_gain) // see [RULE5]
    else $error("first gain set not applied outside window");

  property p_trq_zero; // see [RULE16]
    tick_ff && ctrlMode == svgf_pkg::MODE_TRQ
      |=> offsetAct_ff == 16'h0000 && dynAct_ff == 16'h0000;
  endproperty
  a_trq_zero: assert property (p_trq_zero) // see [RULE16]
    else $error("compensation not zero in torque mode");

  property p_vel; // see [RULE17]
    tick_ff && servoOn && ctrlMode == svgf_pkg::MODE_VEL
      |=> offsetAct_ff == $past(offsetTrq_ff) && dynAct_ff == 16'h0000;
  endproperty
  a_vel: assert property (p_vel) // see [RULE17]
    else $error("velocity mode compensation wrong");

  property p_hold; // see [RULE18]
    tick_ff && servoOn && posMode && !cmdSeen_ff && !cmdPresent
      |=> $stable(offsetAct_ff) && $stable(dynAct_ff);
  endproperty
  a_hold: assert property (p_hold) // see [RULE18]
    else $error("compensation changed before first command");

  property p_dir; // see [RULE19]
    tick_ff && servoOn && posMode && cmdRev |=> dynAct_ff == $past(revFric_ff);
  endproperty
  a_dir: assert property (p_dir) // see [RULE19]
    else $error("reverse friction value not applied");

endmodule // svgf_gain_fric

`default_nettype wire

/* common/svgf_pkg.sv */
/*
  Shared constants and types for the gain selection and friction
  compensation block: register offsets, reset values, control modes,
  gain states and control-cycle timing.
  Assumes a 25 MHz system clock and a word-aligned register port.
*/
`default_nettype none

package svgf_pkg;

  // Clock and control-cycle timing.
  localparam int CLK_PERIOD_NS  = 40;
  localparam int CTRL_PERIOD_NS = 1000;
  localparam int TICK_CYCLES    = (CTRL_PERIOD_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_GAIN1_POS   = 8'h04;
  localparam logic [7:0] OFS_GAIN1_SPD   = 8'h08;
  localparam logic [7:0] OFS_GAIN2_POS   = 8'h0C;
  localparam logic [7:0] OFS_GAIN2_SPD   = 8'h10;
  localparam logic [7:0] OFS_THIRD_TIME  = 8'h14;
  localparam logic [7:0] OFS_THIRD_SCALE = 8'h18;
  localparam logic [7:0] OFS_RAMP_TIME   = 8'h1C;
  localparam logic [7:0] OFS_OFFSET_TRQ  = 8'h20;
  localparam logic [7:0] OFS_FWD_FRIC    = 8'h24;
  localparam logic [7:0] OFS_REV_FRIC    = 8'h28;
  localparam logic [7:0] OFS_VISC_GAIN   = 8'h2C;
  localparam logic [7:0] OFS_STATUS      = 8'h30;
  localparam logic [7:0] OFS_GAIN_NOW    = 8'h34;
  localparam logic [7:0] OFS_COMP_NOW    = 8'h38;

  // Control register fields.
  localparam int CTRL_SERVO_BIT = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int CTRL_TWODOF_BIT = 3;
  localparam int CTRL_SWSEL_LSB = 4;

  // Reset values and the position-command switch selector code.
  localparam logic [15:0] RST_SCALE = 16'h0064;
  localparam logic [15:0] RST_ZERO  = 16'h0000;
  localparam logic [3:0]  SWSEL_POS_CMD = 4'h7;

  // Arithmetic: third gain percentage divisor and viscous shift.
  localparam int PCT_DIV    = 100;
  localparam int VISC_SHIFT = 8;

  typedef enum logic [1:0] {
    MODE_POS   = 2'b00,
    MODE_VEL   = 2'b01,
    MODE_TRQ   = 2'b10,
    MODE_FULLC = 2'b11
  } svgf_mode_t;

  typedef enum logic [1:0] {
    GS_FIRST  = 2'b00,
    GS_SECOND = 2'b01,
    GS_THIRD  = 2'b11
  } svgf_gstate_t;

endpackage

`default_nettype wire

/* common/svgf_gain_if.sv */
/*
  Carrier between the control core and the gain arithmetic unit.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface svgf_gain_if;
  logic [15:0] firstPos;
  logic [15:0] firstSpd;
  logic [15:0] scale;
  logic [15:0] startPos;
  logic [15:0] startSpd;
  logic [15:0] rampCnt;
  logic [15:0] rampTime;
  logic [15:0] thirdPos;
  logic [15:0] thirdSpd;
  logic [15:0] rampPos;
  logic [15:0] rampSpd;

  modport ctrl (
    output firstPos, firstSpd, scale, startPos, startSpd, rampCnt, rampTime,
    input  thirdPos, thirdSpd, rampPos, rampSpd
  );
  modport calc (
    input  firstPos, firstSpd, scale, startPos, startSpd, rampCnt, rampTime,
    output thirdPos, thirdSpd, rampPos, rampSpd
  );
endinterface

`default_nettype wire

/* hdl/svgf_gain_calc.sv */
/*
  Gain arithmetic: scaled third gain and the linear ramp from a start
  gain toward it. Results are registered one clock after the inputs.
  Assumes inputs hold steady for at least two clocks between ticks.
*/
`timescale 1ns/1ps
`default_nettype none

module svgf_gain_calc (
  input  wire logic   clk,
  input  wire logic   reset,
  svgf_gain_if.calc   gif
);

  function automatic logic [15:0] scaleGain(input logic [15:0] g,
                                            input logic [15:0] s);
    logic [31:0] prod;
    logic [31:0] quot;
    prod = 32'(g) * 32'(s);
    quot = prod / 32'(svgf_pkg::PCT_DIV);
    return (quot > 32'h0000_FFFF) ? 16'hFFFF : quot[15:0];
  endfunction

  // Interpolates target + (start - target) * cnt / time.
  function automatic logic [15:0] rampGain(input logic [15:0] tgt,
                                           input logic [15:0] st,
                                           input logic [15:0] cnt,
                                           input logic [15:0] tim);
    logic signed [33:0] diff;
    logic signed [33:0] step;
    diff = 34'(signed'({1'b0, st})) - 34'(signed'({1'b0, tgt}));
    step = 34'sd0;
    if (tim != 16'h0000 && cnt != 16'h0000)
    begin
      step = (diff * 34'(signed'({1'b0, cnt})))
             / 34'(signed'({1'b0, tim}));
    end
    return 16'(34'(signed'({1'b0, tgt})) + step);
  endfunction

  wire logic [15:0] tPos = scaleGain(gif.firstPos, gif.scale);
  wire logic [15:0] tSpd = scaleGain(gif.firstSpd, gif.scale);

  logic [15:0] thirdPos_ff;
  logic [15:0] thirdSpd_ff;
  logic [15:0] rampPos_ff;
  logic [15:0] rampSpd_ff;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      thirdPos_ff <= 16'h0000;
      thirdSpd_ff <= 16'h0000;
      rampPos_ff  <= 16'h0000;
      rampSpd_ff  <= 16'h0000;
    end
    else
    begin
      thirdPos_ff <= tPos; // see [RULE2]
      thirdSpd_ff <= tSpd; // see [RULE2]
      rampPos_ff  <= rampGain(tPos, gif.startPos, gif.rampCnt, gif.rampTime);
      rampSpd_ff  <= rampGain(tSpd, gif.startSpd, gif.rampCnt, gif.rampTime);
    end
  end

  assign gif.thirdPos = thirdPos_ff;
  assign gif.thirdSpd = thirdSpd_ff;
  assign gif.rampPos  = rampPos_ff;
  assign gif.rampSpd  = rampSpd_ff;

  property p_third_scale; // see [RULE2]
    @(posedge clk) disable iff (reset)
    ($past(gif.scale) == svgf_pkg::RST_SCALE && $past(gif.firstPos) < 16'h8000)
      |-> gif.thirdPos == $past(gif.firstPos);
  endproperty
  a_third_scale: assert property (p_third_scale) // see [RULE2]
    else $error("third gain at 100 percent differs from first gain");

endmodule // svgf_gain_calc

`default_nettype wire

/* tb/svgf_host_model.sv */
/* Host model: hands one position command delta per control cycle.
   Assumes the bench queues nextDelta before the next ctrlTick. */
`timescale 1ns/1ps
`default_nettype none
module svgf_host_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ctrlTick,
  input  wire logic [15:0] nextDelta,
  output logic      [15:0] posCmdDelta
);
  // Updating just after the tick keeps the sample window clean.
  always_ff @(posedge clk or posedge reset)
    if (reset)
      posCmdDelta <= 16'h0000;
    else if (ctrlTick)
      posCmdDelta <= nextDelta;
endmodule // svgf_host_model
`default_nettype wire

/* tb/testbench.sv */
/* Self-checking bench for the gain select and friction block.
   Assumes the host model supplies the position command stream. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, reset, regWr, regRd, ctrlTick, swCond;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, rdv;
  logic [15:0] nextDelta, posCmdDelta, posLoopGain, speedPropGain;
  logic [15:0] torqueCmdOut;
  logic [1:0]  gainSelect;
  int          n_errors = 0;
  int          cmp_count = 0;
  typedef struct {logic [7:0] c; logic [15:0] d, t;} svgf_row_t;
  svgf_row_t   rows [6] = '{
    '{8'h01, 16'h0001, 16'h0130},
    '{8'h01, 16'hFFFF, 16'h0140},
    '{8'h03, 16'h0001, 16'h0110},
    '{8'h05, 16'h0001, 16'h0100},
    '{8'h01, 16'h0000, 16'h0100},
    '{8'h09, 16'h0001, 16'h0330}};
  svgf_gain_fric dut_u (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .gainSwitchCond(swCond),
    .posCmdDelta(posCmdDelta), .cmdSpeed(16'h0200),
    .torqueCmdIn(16'h0100), .posLoopGain(posLoopGain),
    .speedPropGain(speedPropGain), .torqueCmdOut(torqueCmdOut),
    .gainSelect(gainSelect), .ctrlTick(ctrlTick));
  svgf_host_model host_u (.clk(clk), .reset(reset), .ctrlTick(ctrlTick),
    .nextDelta(nextDelta), .posCmdDelta(posCmdDelta));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= {16'h0000, d};
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    rdv = regRdata;
  endtask
  // Queue a delta, then let n ticks pass and the outputs settle.
  task automatic run(input logic [15:0] d, input int n);
    @(posedge clk);
    nextDelta <= d;
    repeat (n)
    begin
      @(negedge clk);
      while (ctrlTick !== 1'b1) @(negedge clk);
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic win(input logic [7:0] c, input logic [1:0] e);
    wr(8'h00, {8'h00, c});
    run(16'h0001, 2);
    chk(gainSelect, 2'b01);
    run(16'h0000, 2);
    chk(gainSelect, e);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // The whole run needs well under 5000 clocks; allow ten times that.
  initial
  begin
    #2000000;
    n_errors++;
    tally_and_finish;
  end
  initial
  begin
    {reset, regWr, regRd, regAddr, regWdata, nextDelta, swCond} = '0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk(torqueCmdOut, 16'h0000);
    rd(8'h18);
    chk(rdv, 32'h0000_0064);
    rd(8'h3C);
    chk(rdv, 32'h0000_0000);
    $display("reset test done");
    wr(8'h20, 16'h0010);
    wr(8'h24, 16'h0020);
    wr(8'h28, 16'h0030);
    wr(8'h2C, 16'h0100);
    foreach (rows[i])
    begin
      run(rows[i].d, 1);
      wr(8'h00, {8'h00, rows[i].c});
      run(rows[i].d, 2);
      chk(torqueCmdOut, rows[i].t);
      $display("row %0d done", i);
    end
    wr(8'h04, 16'h0100);
    wr(8'h08, 16'h0200);
    wr(8'h0C, 16'h0050);
    wr(8'h10, 16'h0060);
    wr(8'h14, 16'h0003);
    wr(8'h18, 16'h0096);
    win(8'h71, 2'b11);
    chk(posLoopGain, 16'h0180);
    chk(speedPropGain, 16'h0300);
    run(16'h0000, 3);
    chk(gainSelect, 2'b00);
    chk(posLoopGain, 16'h0100);
    win(8'h71, 2'b11);
    run(16'h0001, 2);
    chk(gainSelect, 2'b01);
    chk(posLoopGain, 16'h0050);
    win(8'h73, 2'b00);
    win(8'h77, 2'b11);
    $display("gain window test done");
    run(16'h0000, 3);
    wr(8'h1C, 16'h0004);
    win(8'h71, 2'b11);
    chk(posLoopGain, 16'h0050);
    run(16'h0000, 1);
    chk(posLoopGain, 16'h009C);
    $display("ramp test done");
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk(gainSelect, 2'b00);
    chk(posLoopGain, 16'h0000);
    rd(8'h30);
    chk(rdv, 32'h0000_0000);
    rd(8'h18);
    chk(rdv, 32'h0000_0064);
    $display("reset recovery test done");
    wr(8'h00, 16'h0001);
    swCond <= 1'b1;
    run(16'h0000, 2);
    chk(gainSelect, 2'b01);
    @(posedge clk);
    swCond <= 1'b0;
    run(16'h0000, 2);
    chk(gainSelect, 2'b00);
    wr(8'h14, 16'h0003);
    swCond <= 1'b1;
    run(16'h0000, 2);
    chk(gainSelect, 2'b01);
    wr(8'h00, 16'h0000);
    swCond <= 1'b0;
    run(16'h0000, 2);
    chk(gainSelect, 2'b00);
    $display("switch condition test done");
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
